// file: dss_top.sv
// primary/secondary command and frequency source selector
// Function
// RL1 - selection off primary, on secondary settings
// RL2 - command and frequency sources switch together
// RL3 - terminal selects only with function code 22
// RL4 - code 0 keypad keys, code 3 serial
// RL5 - code 1: forward input forward, reverse reverse
// RL6 - code 2: forward runs, reverse sets direction
// RL7 - frequency codes 0 to 10 decoded
// RL8 - secondary set uses identical code meanings
// RL9 - terminals four, five only on advanced
// RL10 - serial and some analog codes advanced only
// RL11 - to secondary, forward asserted keeps running
// RL12 - back to primary, stop command stops
// RL13 - to secondary mode 1, forward off stops
// RL14 - operator checks secondary settings before switching
// RL15 - selection input synchronised before use
`timescale 1ns/1ps
`default_nettype none
`include "dss_defs.svh"
module dss_top
  import dss_pkg::*;
#(
  parameter bit ADV_IO = 1'b1
) (
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  input  wire logic [`DSS_NTERM_MAX-1:0]         term_in,
  input  wire dss_func_t [`DSS_NTERM_MAX-1:0]    input_terminal_function,
  input  wire dss_src_cfg_s                      prim_cfg,
  input  wire dss_src_cfg_s                      sec_cfg,
  input  wire logic                              key_run,
  input  wire logic                              key_stop,
  input  wire logic                              forward_run_input,
  input  wire logic                              reverse_run_input,
  input  wire logic                              ser_run,
  input  wire logic                              ser_rev,
  output logic                                   secondary_set_select_q,
  output dss_src_cfg_s                           act_cfg_q,
  output dss_fsrc_e                              freq_src_q,
  output logic                                   run_q,
  output logic                                   dir_rev_q,
  output logic                                   prim_err_q,
  output logic                                   sec_err_q,
  output logic                                   act_err_q
);
  localparam int NTERM = ADV_IO ? `DSS_NTERM_MAX : `DSS_NTERM_STD;

  generate
    if (NTERM > `DSS_NTERM_MAX) begin : g_bad_cfg
      $error("dss_top: terminal count exceeds port width");
    end
  endgenerate

  // frequency code decode, shared by both sets so meanings match
  function automatic dss_fsrc_e frq_map(logic [`DSS_FRQ_W-1:0] c,
                                        bit adv);
    dss_fsrc_e r;
    r = DSS_FS_NONE;
    case (c)
      4'h0, 4'h1: r = DSS_FS_KEYPAD;                    // [RL7]
      4'h2:       r = DSS_FS_POT;
      4'h3:       r = DSS_FS_VOLT;
      4'h4:       r = adv ? DSS_FS_CURR : DSS_FS_NONE;  // [RL10]
      4'h5:       r = adv ? DSS_FS_SEC_VOLT : DSS_FS_NONE;
      4'h6:       r = adv ? DSS_FS_POT_CURR : DSS_FS_NONE;
      4'h7:       r = adv ? DSS_FS_POT_SECV : DSS_FS_NONE;
      4'h8:       r = DSS_FS_POT_VOLT;
      4'h9:       r = adv ? DSS_FS_SERIAL : DSS_FS_NONE;
      4'ha:       r = DSS_FS_UPDOWN;
      default:    r = DSS_FS_NONE;
    endcase
    return r;
  endfunction : frq_map

  function automatic logic cmd_bad(dss_cmd_e c, bit adv);
    return (c == DSS_CMD_SERIAL) && !adv;               // [RL10]
  endfunction : cmd_bad

  // selection terminal synchronisers
  logic [`DSS_NTERM_MAX-1:0] sync1_q;
  logic [`DSS_NTERM_MAX-1:0] sync2_q;
  logic [`DSS_NTERM_MAX-1:0] hit;
  logic                      sel_q;
  dss_kp_e                   kp_q;

  genvar gi;
  generate
    for (gi = 0; gi < `DSS_NTERM_MAX; gi++) begin : g_term
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= term_in[gi];                   // [RL15]
          sync2_q[gi] <= sync1_q[gi];                   // [RL15]
        end
      end
      // unfitted terminals on the standard variant never select
      assign hit[gi] = (gi < NTERM) && sync2_q[gi] &&   // [RL9]
        (input_terminal_function[gi] == `DSS_FUNC_SECOND_SRC); // [RL3]
    end
  endgenerate

  wire          sel_d   = |hit;
  // one mux of the whole struct keeps both sources in step
  dss_src_cfg_s cfg_d;
  assign cfg_d = sel_q ? sec_cfg : prim_cfg;            // [RL1] [RL2] [RL8]

  wire dec_run;
  wire dec_rev;
  wire dec_ok;
  dss_cmd_dec #(.ADV_IO(ADV_IO)) u_dec (
    .cmd     (act_cfg_q.cmd),
    .kp_run  (kp_q == DSS_KP_RUN),
    .fwd_in  (forward_run_input),
    .rev_in  (reverse_run_input),
    .ser_run (ser_run),
    .ser_rev (ser_rev),
    .run     (dec_run),
    .dir_rev (dec_rev),
    .ok      (dec_ok)
  );

  wire       is_kp = act_cfg_q.cmd == DSS_CMD_KEYPAD;
  // stop key wins; entering keypad control always starts stopped
  dss_kp_e   kp_d;
  assign kp_d = (!is_kp || key_stop) ? DSS_KP_STOP :    // [RL4]
                key_run ? DSS_KP_RUN : kp_q;
  dss_fsrc_e fs_d;
  assign fs_d = frq_map(act_cfg_q.frq, ADV_IO);         // [RL7] [RL8]
  wire       aerr_d = !dec_ok || (fs_d == DSS_FS_NONE);
  wire       perr_d = cmd_bad(prim_cfg.cmd, ADV_IO) ||
                      (frq_map(prim_cfg.frq, ADV_IO) == DSS_FS_NONE);
  wire       serr_d = cmd_bad(sec_cfg.cmd, ADV_IO) ||
                      (frq_map(sec_cfg.frq, ADV_IO) == DSS_FS_NONE);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q                  <= 1'b0;
      secondary_set_select_q <= 1'b0;
      act_cfg_q              <= '{cmd: dss_cmd_e'(`DSS_RST_CMD),
                                  frq: `DSS_RST_FRQ};
      kp_q                   <= DSS_KP_STOP;
    end else begin
      sel_q                  <= sel_d;                  // [RL1]
      secondary_set_select_q <= sel_q;
      act_cfg_q              <= cfg_d;                  // [RL2]
      kp_q                   <= kp_d;
    end
  end

  // run follows the newly active source at once, so a switch keeps
  // running or stops purely by what that source presents
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q      <= 1'b0;
      dir_rev_q  <= 1'b0;
      freq_src_q <= DSS_FS_NONE;
      prim_err_q <= 1'b0;
      sec_err_q  <= 1'b0;
      act_err_q  <= 1'b0;
    end else begin
      run_q      <= dec_run;                            // [RL11] [RL12] [RL13]
      dir_rev_q  <= dec_rev;
      freq_src_q <= fs_d;
      prim_err_q <= perr_d;                             // [RL10]
      sec_err_q  <= serr_d;
      act_err_q  <= aerr_d;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence kp_stop_s;
    key_stop && is_kp ##1 is_kp;
  endsequence
  sequence to_sec_s;
    $rose(sel_q) ##1 act_cfg_q.cmd == DSS_CMD_TERM1;
  endsequence
  sequence to_prim_s;
    $fell(sel_q) ##1 act_cfg_q.cmd == DSS_CMD_SERIAL;
  endsequence

  sel_primary_a: assert property (                      // [RL1]
    !sel_q |=> act_cfg_q == $past(prim_cfg))
    else $error("primary set not applied");
  sel_secondary_a: assert property (                    // [RL2]
    sel_q |=> act_cfg_q.cmd == $past(sec_cfg.cmd) &&
              act_cfg_q.frq == $past(sec_cfg.frq))
    else $error("secondary sources not switched together");
  func_code_a: assert property (                        // [RL3]
    !(|hit) |=> !sel_q)
    else $error("selection without function 22 terminal");
  sync_delay_a: assert property (                       // [RL15]
    (term_in[0] && input_terminal_function[0] == `DSS_FUNC_SECOND_SRC)
      [*3] |=> sel_q)
    else $error("synchronised selection late");
  keypad_stop_a: assert property (                      // [RL4]
    kp_stop_s |=> !run_q)
    else $error("keypad stop ignored");
  term1_fwd_a: assert property (                        // [RL5]
    act_cfg_q.cmd == DSS_CMD_TERM1 && forward_run_input &&
    !reverse_run_input |=> run_q && !dir_rev_q)
    else $error("mode 1 forward wrong");
  term2_dir_a: assert property (                        // [RL6]
    act_cfg_q.cmd == DSS_CMD_TERM2 && forward_run_input
      |=> run_q && dir_rev_q == $past(reverse_run_input))
    else $error("mode 2 run or direction wrong");
  freq_volt_a: assert property (                        // [RL7]
    act_cfg_q.frq == 4'h3 |=> freq_src_q == DSS_FS_VOLT)
    else $error("voltage source not decoded");
  same_codes_a: assert property (                       // [RL8]
    secondary_set_select_q && act_cfg_q.frq == 4'ha
      |=> freq_src_q == DSS_FS_UPDOWN)
    else $error("secondary code meaning differs");
  std_terms_a: assert property (                        // [RL9]
    !ADV_IO && !(|hit[`DSS_NTERM_STD-1:0]) |=> !sel_q)
    else $error("unfitted terminal selected");
  adv_only_a: assert property (                         // [RL10]
    !ADV_IO && act_cfg_q.frq == 4'h9
      |=> freq_src_q == DSS_FS_NONE && act_err_q)
    else $error("advanced code accepted on standard");
  keep_run_a: assert property (                         // [RL11]
    to_sec_s ##0 (forward_run_input && !reverse_run_input) |=> run_q)
    else $error("run interrupted on switch");
  back_stop_a: assert property (                        // [RL12]
    to_prim_s ##0 !ser_run |=> !run_q)
    else $error("no stop on switch back");
  sec_stop_a: assert property (                         // [RL13]
    to_sec_s ##0 (!forward_run_input && !reverse_run_input) |=> !run_q)
    else $error("no stop with forward off");
endmodule : dss_top
`default_nettype wire

// file: dss_defs.svh
// constants for the dual source selector
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH
`define DSS_FUNC_W          5
`define DSS_FUNC_SECOND_SRC 5'h16
`define DSS_NTERM_MAX       5
`define DSS_NTERM_STD       3
`define DSS_CMD_W           2
`define DSS_FRQ_W           4
`define DSS_RST_CMD         2'h1
`define DSS_RST_FRQ         4'h0
`endif

// file: dss_pkg.sv
// types for the dual source selector
`default_nettype none
`include "dss_defs.svh"
package dss_pkg;
  typedef enum logic [1:0] {
    DSS_CMD_KEYPAD = 2'h0,
    DSS_CMD_TERM1  = 2'h1,
    DSS_CMD_TERM2  = 2'h2,
    DSS_CMD_SERIAL = 2'h3
  } dss_cmd_e;

  typedef enum logic [3:0] {
    DSS_FS_KEYPAD   = 4'h0,
    DSS_FS_POT      = 4'h1,
    DSS_FS_VOLT     = 4'h2,
    DSS_FS_CURR     = 4'h3,
    DSS_FS_SEC_VOLT = 4'h4,
    DSS_FS_POT_CURR = 4'h5,
    DSS_FS_POT_SECV = 4'h6,
    DSS_FS_POT_VOLT = 4'h7,
    DSS_FS_SERIAL   = 4'h8,
    DSS_FS_UPDOWN   = 4'h9,
    DSS_FS_NONE     = 4'hf
  } dss_fsrc_e;

  typedef enum logic {
    DSS_KP_STOP = 1'b0,
    DSS_KP_RUN  = 1'b1
  } dss_kp_e;

  typedef struct packed {
    dss_cmd_e                  cmd;
    logic [`DSS_FRQ_W-1:0]     frq;
  } dss_src_cfg_s;

  typedef logic [`DSS_FUNC_W-1:0] dss_func_t;
endpackage : dss_pkg
`default_nettype wire

// file: dss_cmd_dec.sv
// run command decoder for one command source code
`timescale 1ns/1ps
`default_nettype none
module dss_cmd_dec
  import dss_pkg::*;
#(
  parameter bit ADV_IO = 1'b1
) (
  input  wire dss_cmd_e cmd,
  input  wire logic     kp_run,
  input  wire logic     fwd_in,
  input  wire logic     rev_in,
  input  wire logic     ser_run,
  input  wire logic     ser_rev,
  output logic          run,
  output logic          dir_rev,
  output logic          ok
);
  wire t1_run = fwd_in ^ rev_in;
  // both terminals on in mode 1 is contradictory, so it stops
  always_comb begin
    run     = 1'b0;
    dir_rev = 1'b0;
    ok      = 1'b1;
    case (cmd)
      DSS_CMD_KEYPAD: begin
        run = kp_run;                                   // [RL4]
      end
      DSS_CMD_TERM1: begin
        run     = t1_run;                               // [RL5]
        dir_rev = rev_in & ~fwd_in;                     // [RL5]
      end
      DSS_CMD_TERM2: begin
        run     = fwd_in;                               // [RL6]
        dir_rev = rev_in;                               // [RL6]
      end
      DSS_CMD_SERIAL: begin
        ok      = ADV_IO;                               // [RL10]
        run     = ADV_IO & ser_run;                     // [RL4]
        dir_rev = ADV_IO & ser_rev;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
  end
endmodule : dss_cmd_dec
`default_nettype wire

// file: dss_operator.sv
// operator side model: terminals, keypad and serial master
`timescale 1ns/1ps
`default_nettype none
module dss_operator (
  input  wire logic       mclk,
  input  wire logic [4:0] want_term,
  input  wire logic [5:0] want_lines,
  output logic      [4:0] term_in,
  output logic            key_run,
  output logic            key_stop,
  output logic            fwd,
  output logic            rev,
  output logic            ser_run,
  output logic            ser_rev
);
  logic [4:0] term_s;
  logic [4:0] term_hold = '0;
  logic [5:0] lines_s;
  // requests taken at the edge, key and run lines shown just after it, terminals one edge later
  always @(posedge mclk) begin
    term_s = want_term;
    lines_s = want_lines;
    #1;
    {key_run, key_stop, fwd, rev, ser_run, ser_rev} = lines_s;
    // selection lags settings by a cycle, settings checked first
    term_in = term_hold;
    term_hold = term_s;
  end
endmodule : dss_operator
`default_nettype wire

// file: dual_source_selector_tb.sv
// self-checking bench for the dual source selector
`timescale 1ns/1ps
`default_nettype none
`include "dss_defs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module dual_source_selector_tb
  import dss_pkg::*;
;
  logic            mclk = 1'b0;
  logic            sys_rst = 1'b1;
  logic [4:0]      want_term = '0;
  logic [5:0]      want_lines = '0;
  dss_func_t [4:0] func = '0;
  dss_src_cfg_s    prim = '0;
  dss_src_cfg_s    sec = '0;
  logic [4:0]      term_in;
  logic            key_run, key_stop, fwd, rev, ser_run, ser_rev;
  logic            sel_a, run_a, dir_a, perr_a, serr_a, sel_s, aerr_s;
  logic            aerr_a;
  dss_src_cfg_s    act_a;
  dss_fsrc_e       fs_a;
  int              n_errors = 0;
  int              tests_run = 0;

  always #25 mclk = ~mclk;

  dss_operator u_dss_operator (.mclk(mclk), .want_term(want_term),
    .want_lines(want_lines), .term_in(term_in), .key_run(key_run),
    .key_stop(key_stop), .fwd(fwd), .rev(rev), .ser_run(ser_run),
    .ser_rev(ser_rev));
  dss_top #(.ADV_IO(1'b1)) u_dss_top (.mclk(mclk), .sys_rst(sys_rst),
    .term_in(term_in), .input_terminal_function(func), .prim_cfg(prim),
    .sec_cfg(sec), .key_run(key_run), .key_stop(key_stop),
    .forward_run_input(fwd), .reverse_run_input(rev), .ser_run(ser_run),
    .ser_rev(ser_rev), .secondary_set_select_q(sel_a), .act_cfg_q(act_a),
    .freq_src_q(fs_a), .run_q(run_a), .dir_rev_q(dir_a),
    .prim_err_q(perr_a), .sec_err_q(serr_a), .act_err_q(aerr_a));
  // standard variant shares every input
  dss_top #(.ADV_IO(1'b0)) u_dss_top_std (.mclk(mclk), .sys_rst(sys_rst),
    .term_in(term_in), .input_terminal_function(func), .prim_cfg(prim),
    .sec_cfg(sec), .key_run(key_run), .key_stop(key_stop),
    .forward_run_input(fwd), .reverse_run_input(rev), .ser_run(ser_run),
    .ser_rev(ser_rev), .secondary_set_select_q(sel_s), .act_cfg_q(),
    .freq_src_q(), .run_q(), .dir_rev_q(), .prim_err_q(), .sec_err_q(),
    .act_err_q(aerr_s));

  function automatic dss_fsrc_e exp_fs(input logic [3:0] c, input bit adv);
    if (c > 4'ha || (!adv && c inside {4'h4, 4'h5, 4'h6, 4'h7, 4'h9}))
      return DSS_FS_NONE;
    return (c < 4'h2) ? DSS_FS_KEYPAD : dss_fsrc_e'(c - 4'h1);
  endfunction : exp_fs

  function automatic logic exp_err(input dss_src_cfg_s c, input bit adv);
    return exp_fs(c.frq, adv) == DSS_FS_NONE ||
           (!adv && c.cmd == DSS_CMD_SERIAL);
  endfunction : exp_err

  // {run, reverse} for terminal and serial codes; l as in want_lines
  function automatic logic [1:0] exp_rd(input dss_cmd_e c,
                                        input logic [5:0] l);
    case (c)
      DSS_CMD_TERM1: return {l[3] ^ l[2], l[2] & ~l[3]};
      DSS_CMD_TERM2: return {l[3], l[2]};
      DSS_CMD_SERIAL: return l[1:0];
      default: return 2'b00;
    endcase
  endfunction : exp_rd

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic check_all();
    logic sa;
    logic ss;
    dss_src_cfg_s c;
    logic [1:0] rd;
    sa = 1'b0;
    ss = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (term_in[i] && func[i] == `DSS_FUNC_SECOND_SRC) begin
        sa = 1'b1;
        if (i < 3) ss = 1'b1;
      end
    end
    c = sa ? sec : prim;
    rd = exp_rd(c.cmd, want_lines);
    `CHK("select", sa, sel_a)
    `CHK("select std", ss, sel_s)
    `CHK("active cfg", c, act_a)
    `CHK("freq src", exp_fs(c.frq, 1'b1), fs_a)
    `CHK("run", rd[1], run_a)
    if (rd[1]) `CHK("dir", rd[0], dir_a)
    `CHK("prim err", exp_err(prim, 1'b1), perr_a)
    `CHK("sec err", exp_err(sec, 1'b1), serr_a)
    `CHK("std err", exp_err(ss ? sec : prim, 1'b0), aerr_s)
    `CHK("act err", exp_err(c, 1'b1), aerr_a)
  endtask : check_all

  task automatic conclude();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    #(50 * 4000);
    n_errors++;
    conclude();
  end

  initial begin
    void'($urandom(32'h7ab5));
    tick(3);
    `CHK("rst run", 1'b0, run_a)
    `CHK("rst cfg", {`DSS_RST_CMD, `DSS_RST_FRQ}, act_a)
    tick(3);
    sys_rst = 1'b0;
    tick(1);
    // random settings with hand-picked boundaries mixed in
    for (int k = 0; k < 60; k++) begin
      prim = dss_src_cfg_s'({2'($urandom_range(3, 1)), 4'($urandom)});
      sec = dss_src_cfg_s'({2'($urandom_range(3, 1)), 4'($urandom)});
      for (int i = 0; i < 5; i++)
        func[i] = ($urandom_range(2) == 0) ? `DSS_FUNC_SECOND_SRC
                                            : 5'($urandom_range(27));
      want_term = 5'($urandom);
      want_lines = {2'b00, 4'($urandom)};
      if (k == 0) func = {5{5'h15}};
      if (k == 1) begin
        func = '0;
        func[4] = `DSS_FUNC_SECOND_SRC;
        want_term = 5'h10;
      end
      if (k == 2) {prim.frq, sec.frq} = {4'ha, 4'hb};
      tick(8);
      check_all();
    end
    // toggle only the selection; never a half-switched set
    func = '0;
    func[0] = `DSS_FUNC_SECOND_SRC;
    prim = {DSS_CMD_TERM2, 4'h3};
    sec = {DSS_CMD_SERIAL, 4'h9};
    want_term = 5'h00;
    tick(8);
    want_term = 5'h01;
    repeat (10) begin
      tick(1);
      `CHK("paired", 1'b1, act_a === prim || act_a === sec)
    end
    // switching while running, serial primary, terminal mode 1 secondary
    func = '0;
    func[4] = `DSS_FUNC_SECOND_SRC;
    prim = {DSS_CMD_SERIAL, 4'h0};
    sec = {DSS_CMD_TERM1, 4'h0};
    want_term = 5'h00;
    want_lines = 6'b001010;
    tick(8);
    want_term = 5'h10;
    repeat (12) begin
      tick(1);
      `CHK("keep running", 1'b1, run_a)
    end
    want_term = 5'h00;
    want_lines = 6'b001000;
    tick(8);
    `CHK("back stops", 1'b0, run_a)
    want_lines = 6'b000010;
    tick(8);
    `CHK("serial runs", 1'b1, run_a)
    want_term = 5'h10;
    tick(8);
    `CHK("mode1 stops", 1'b0, run_a)
    // keypad keys; stop wins over run in the same cycle
    want_term = 5'h00;
    want_lines = 6'b000000;
    prim = {DSS_CMD_KEYPAD, 4'h0};
    tick(8);
    want_lines = 6'b100000;
    tick(1);
    want_lines = 6'b000000;
    tick(6);
    `CHK("key run", 1'b1, run_a)
    `CHK("key dir", 1'b0, dir_a)
    want_lines = 6'b110000;
    tick(1);
    want_lines = 6'b000000;
    tick(6);
    `CHK("key stop", 1'b0, run_a)
    conclude();
  end
endmodule : dual_source_selector_tb
`default_nettype wire
